// [verilog/event_input_regs.svh]
`ifndef EVENT_INPUT_REGS_SVH
`define EVENT_INPUT_REGS_SVH

`define EVI_ADDR_CTRL      8'h00
`define EVI_ADDR_STATUS    8'h04
`define EVI_ADDR_MASK      8'h08
`define EVI_ADDR_NOM_FREQ  8'h0c
`define EVI_ADDR_PERIOD    8'h10
`define EVI_ADDR_TSTAMP    8'h14
`define EVI_ADDR_LEVELS    8'h18

`define EVI_CTRL_FN0_LSB   0
`define EVI_CTRL_FN1_LSB   2
`define EVI_CTRL_PSM_BIT   4
`define EVI_CTRL_ANT_BIT   5
`define EVI_CTRL_W         6
`define EVI_CTRL_RST       6'h00

`define EVI_ST_EV0         0
`define EVI_ST_EV1         1
`define EVI_ST_TSYNC       2
`define EVI_ST_FERR        3
`define EVI_ST_ANT         4
`define EVI_ST_W           5
`define EVI_ST_RST         5'h00
`define EVI_MASK_RST       5'h00

`define EVI_CLK_PERIOD_NS  10
`define EVI_MIN_PHASE_NS   50
`define EVI_MAX_FREQ_KHZ   500
`define EVI_MIN_PERIOD_NS  (1000000 / `EVI_MAX_FREQ_KHZ)
`define EVI_MIN_PHASE_CYC  ((`EVI_MIN_PHASE_NS + `EVI_CLK_PERIOD_NS - 1) / `EVI_CLK_PERIOD_NS)
`define EVI_MIN_PERIOD_CYC ((`EVI_MIN_PERIOD_NS + `EVI_CLK_PERIOD_NS - 1) / `EVI_CLK_PERIOD_NS)

`endif

// [verilog/event_input_pkg.sv]
package event_input_pkg;

  // Function assigned to one event input; the order gives the CTRL field codes.
  typedef enum logic [1:0] {
    fn_none,
    fn_pin_ctrl,
    fn_time_aid,
    fn_freq_aid
  } input_fn_t;

endpackage : event_input_pkg

// [verilog/event_input_if.sv]
`timescale 1ns/1ps
interface event_input_if #(
  parameter int PERIOD_W = 24
);
  logic                level;
  logic                rise;
  logic                short_phase;
  logic                period_done;
  logic [PERIOD_W-1:0] period;

  modport src (output level, rise, short_phase, period_done, period);
  modport dst (input  level, rise, short_phase, period_done, period);
endinterface : event_input_if

// [verilog/event_input_channel.sv]
`timescale 1ns/1ps
`include "event_input_regs.svh"
module event_input_channel #(
  parameter int MIN_PHASE_CYC = `EVI_MIN_PHASE_CYC,
  parameter int PERIOD_W      = 24
) (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   pin_async,
  event_input_if.src  ch
);
  logic                sync1_ff;
  logic                sync2_ff;
  logic                prev_ff;
  logic                seen_ff;
  logic [PERIOD_W-1:0] phase_cnt_ff;
  logic [PERIOD_W-1:0] period_cnt_ff;
  logic                edge_any;
  logic                rise;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      sync1_ff <= pin_async;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign edge_any = sync2_ff ^ prev_ff;
  assign rise     = sync2_ff & ~prev_ff;

  // Counters start saturated so the first edge after reset is never judged short.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_cnt_ff  <= '1;
      period_cnt_ff <= '1;
      seen_ff       <= 1'b0;
    end else begin
      if (edge_any)
        phase_cnt_ff <= PERIOD_W'(1);
      else if (phase_cnt_ff != '1)
        phase_cnt_ff <= phase_cnt_ff + PERIOD_W'(1);
      if (rise)
        period_cnt_ff <= PERIOD_W'(1);
      else if (period_cnt_ff != '1)
        period_cnt_ff <= period_cnt_ff + PERIOD_W'(1);
      if (rise)
        seen_ff <= 1'b1;
    end
  end

  assign ch.level       = sync2_ff;
  assign ch.rise        = rise;
  assign ch.short_phase = edge_any && (phase_cnt_ff < PERIOD_W'(MIN_PHASE_CYC));
  assign ch.period_done = rise && seen_ff;
  assign ch.period      = period_cnt_ff;

  property p_sync_rise;
    @(posedge clk) disable iff (!resetn)
      rise |-> $past(pin_async, 2) && !$past(sync2_ff);
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("Rise not two stages after pin.");

endmodule : event_input_channel

// [verilog/external_event_input_control.sv]
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "event_input_regs.svh"
module external_event_input_control #(
  parameter int PERIOD_W = 24
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        event_input_0,
  input  wire logic        event_input_1,
  input  wire logic        auto_active,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  output logic             irq,
  output logic             receiver_active,
  output logic             force_off,
  output logic             time_sync_pulse,
  output logic             freq_ref_pulse,
  output logic             antenna_open
);
  event_input_if #(.PERIOD_W(PERIOD_W)) ch0 ();
  event_input_if #(.PERIOD_W(PERIOD_W)) ch1 ();

  event_input_channel #(
    .MIN_PHASE_CYC (`EVI_MIN_PHASE_CYC),
    .PERIOD_W      (PERIOD_W)
  ) u_ch0 (
    .clk       (clk),
    .resetn    (resetn),
    .pin_async (event_input_0),
    .ch        (ch0.src)
  );

  event_input_channel #(
    .MIN_PHASE_CYC (`EVI_MIN_PHASE_CYC),
    .PERIOD_W      (PERIOD_W)
  ) u_ch1 (
    .clk       (clk),
    .resetn    (resetn),
    .pin_async (event_input_1),
    .ch        (ch1.src)
  );

  logic [`EVI_CTRL_W-1:0] ctrl_ff;
  logic [`EVI_ST_W-1:0]   status_ff;
  logic [`EVI_ST_W-1:0]   mask_ff;
  logic [31:0]            nom_freq_ff;
  logic [PERIOD_W-1:0]    period_ff;
  logic [31:0]            tstamp_ff;
  logic [31:0]            timebase_ff;
  logic [31:0]            rdata_ff;
  logic                   receiver_active_ff;
  logic                   force_off_ff;
  logic                   time_sync_ff;
  logic                   freq_ref_ff;
  logic                   antenna_open_ff;

  event_input_pkg::input_fn_t fn0;
  event_input_pkg::input_fn_t fn1;
  logic                   psm_on;
  logic                   ant_en;
  logic                   ev1_en;
  logic                   pin_sel0;
  logic                   pin_sel1;
  logic                   pin_level;
  logic                   time_edge;
  logic                   freq_sel0;
  logic                   freq_sel1;
  logic                   freq_armed;
  logic                   freq_done;
  logic                   freq_bad;
  logic [PERIOD_W-1:0]    freq_period;
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   wr_mask;
  logic                   wr_nom;
  logic [`EVI_ST_W-1:0]   st_set;
  logic [`EVI_ST_W-1:0]   st_clr;
  logic                   nxt_active;
  logic                   nxt_force_off;
  logic                   nxt_antenna_open;

  assign fn0    = event_input_pkg::input_fn_t'(ctrl_ff[`EVI_CTRL_FN0_LSB +: 2]);
  assign fn1    = event_input_pkg::input_fn_t'(ctrl_ff[`EVI_CTRL_FN1_LSB +: 2]);
  assign psm_on = ctrl_ff[`EVI_CTRL_PSM_BIT];
  assign ant_en = ctrl_ff[`EVI_CTRL_ANT_BIT];
  // Input 1 loses its event function while it serves as the antenna detector.
  assign ev1_en = ~ant_en;

  // Input 0 wins when both inputs nominate the same function.
  assign pin_sel0  = (fn0 == event_input_pkg::fn_pin_ctrl);
  assign pin_sel1  = ~pin_sel0 && ev1_en && (fn1 == event_input_pkg::fn_pin_ctrl);
  assign pin_level = pin_sel0 ? ch0.level : ch1.level;

  // Pin control overrides the on/off cycle while power save runs.
  always_comb begin
    nxt_active    = 1'b1;
    nxt_force_off = 1'b0;
    if (psm_on) begin
      nxt_active = (pin_sel0 || pin_sel1) ? pin_level : auto_active;
    end else if ((pin_sel0 || pin_sel1) && !pin_level) begin
      nxt_active    = 1'b0;
      nxt_force_off = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      receiver_active_ff <= 1'b1;
      force_off_ff       <= 1'b0;
    end else begin
      receiver_active_ff <= nxt_active;
      force_off_ff       <= nxt_force_off;
    end
  end

  // Time aiding: a rising edge stamps the old time base and realigns it to zero.
  always_comb begin
    if (fn0 == event_input_pkg::fn_time_aid)
      time_edge = ch0.rise;
    else
      time_edge = ev1_en && (fn1 == event_input_pkg::fn_time_aid) && ch1.rise;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timebase_ff  <= 32'h0000_0000;
      tstamp_ff    <= 32'h0000_0000;
      time_sync_ff <= 1'b0;
    end else begin
      timebase_ff  <= time_edge ? 32'h0000_0000 : timebase_ff + 32'h0000_0001;
      time_sync_ff <= time_edge;
      if (time_edge)
        tstamp_ff <= timebase_ff;
    end
  end

  // Frequency reference pulses and period capture are only honoured once software has given a nominal frequency.
  assign freq_sel0   = (fn0 == event_input_pkg::fn_freq_aid);
  assign freq_sel1   = ~freq_sel0 && ev1_en && (fn1 == event_input_pkg::fn_freq_aid);
  assign freq_armed  = (nom_freq_ff != 32'h0000_0000);
  assign freq_done   = freq_sel0 ? ch0.period_done : (freq_sel1 && ch1.period_done);
  assign freq_period = freq_sel0 ? ch0.period : ch1.period;
  // Phases under 50 ns or periods under 2 us break the source's limits.
  assign freq_bad    = (freq_sel0 && ch0.short_phase) || (freq_sel1 && ch1.short_phase) ||
                       (freq_done && (freq_period < PERIOD_W'(`EVI_MIN_PERIOD_CYC)));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_ff   <= '0;
      freq_ref_ff <= 1'b0;
    end else begin
      freq_ref_ff <= freq_done && freq_armed;
      if (freq_done && freq_armed)
        period_ff <= freq_period;
    end
  end

  // Antenna detector reads a low level on input 1 as an open circuit.
  assign nxt_antenna_open = ant_en && !ch1.level;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      antenna_open_ff <= 1'b0;
    else
      antenna_open_ff <= nxt_antenna_open;
  end

  // Register writes.
  assign wr_ctrl   = wr_en && (addr == `EVI_ADDR_CTRL);
  assign wr_status = wr_en && (addr == `EVI_ADDR_STATUS);
  assign wr_mask   = wr_en && (addr == `EVI_ADDR_MASK);
  assign wr_nom    = wr_en && (addr == `EVI_ADDR_NOM_FREQ);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff     <= `EVI_CTRL_RST;
      mask_ff     <= `EVI_MASK_RST;
      nom_freq_ff <= 32'h0000_0000;
    end else begin
      if (wr_ctrl)
        ctrl_ff <= wdata[`EVI_CTRL_W-1:0];
      if (wr_mask)
        mask_ff <= wdata[`EVI_ST_W-1:0];
      if (wr_nom)
        nom_freq_ff <= wdata;
    end
  end

  // Sticky status: a set in the same cycle as its clear wins.
  always_comb begin
    st_set                = '0;
    st_set[`EVI_ST_EV0]   = ch0.rise;
    st_set[`EVI_ST_EV1]   = ev1_en && ch1.rise;
    st_set[`EVI_ST_TSYNC] = time_edge;
    st_set[`EVI_ST_FERR]  = freq_bad;
    st_set[`EVI_ST_ANT]   = nxt_antenna_open && !antenna_open_ff;
    st_clr                = wr_status ? wdata[`EVI_ST_W-1:0] : '0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      status_ff <= `EVI_ST_RST;
    else
      status_ff <= (status_ff & ~st_clr) | st_set;
  end

  // Read data stand in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        `EVI_ADDR_CTRL:     rdata_ff <= 32'(ctrl_ff);
        `EVI_ADDR_STATUS:   rdata_ff <= 32'(status_ff);
        `EVI_ADDR_MASK:     rdata_ff <= 32'(mask_ff);
        `EVI_ADDR_NOM_FREQ: rdata_ff <= nom_freq_ff;
        `EVI_ADDR_PERIOD:   rdata_ff <= 32'(period_ff);
        `EVI_ADDR_TSTAMP:   rdata_ff <= tstamp_ff;
        `EVI_ADDR_LEVELS:   rdata_ff <= {29'h0, antenna_open_ff, ch1.level, ch0.level};
        default:            rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign rdata           = rdata_ff;
  assign irq             = |(status_ff & mask_ff);
  assign receiver_active = receiver_active_ff;
  assign force_off       = force_off_ff;
  assign time_sync_pulse = time_sync_ff;
  assign freq_ref_pulse  = freq_ref_ff;
  assign antenna_open    = antenna_open_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_fn_route;
    (ant_en == 1'b0) && (fn0 == event_input_pkg::fn_none) &&
    (fn1 == event_input_pkg::fn_time_aid) && ch1.rise |=> time_sync_pulse;
  endproperty
  a_fn_route: assert property (p_fn_route) else $error("Input 1 time edge not routed.");

  property p_pin_ctrl;
    psm_on && pin_sel0 |=> receiver_active == $past(ch0.level);
  endproperty
  a_pin_ctrl: assert property (p_pin_ctrl) else $error("Pin level did not set activity.");

  property p_pin_psm_auto;
    psm_on && !pin_sel0 && !pin_sel1 |=> receiver_active == $past(auto_active);
  endproperty
  a_pin_psm_auto: assert property (p_pin_psm_auto) else $error("Cycle not followed.");

  property p_force_off;
    !psm_on && pin_sel0 && !ch0.level |=> force_off && !receiver_active;
  endproperty
  a_force_off: assert property (p_force_off) else $error("Low pin did not force off.");

  property p_no_force;
    !psm_on && !(pin_sel0 || pin_sel1) |=> !force_off && receiver_active;
  endproperty
  a_no_force: assert property (p_no_force) else $error("Receiver off without a pin.");

  sequence s_time_edge;
    (fn0 == event_input_pkg::fn_time_aid) && ch0.rise;
  endsequence
  sequence s_time_aligned;
    time_sync_pulse && (timebase_ff == 32'h0000_0000) ##1 (timebase_ff == 32'h0000_0001);
  endsequence
  property p_time_sync;
    s_time_edge |=> s_time_aligned;
  endproperty
  a_time_sync: assert property (p_time_sync) else $error("Time base not realigned.");

  property p_time_stamp;
    s_time_edge |=> tstamp_ff == $past(timebase_ff);
  endproperty
  a_time_stamp: assert property (p_time_stamp) else $error("Time stamp not captured.");

  property p_ant_open;
    ant_en && !ch1.level [*2] |=> antenna_open && !freq_sel1 && !pin_sel1;
  endproperty
  a_ant_open: assert property (p_ant_open) else $error("Open antenna not flagged.");

  property p_ant_off;
    !ant_en |=> !antenna_open;
  endproperty
  a_ant_off: assert property (p_ant_off) else $error("Antenna flag without detector.");

  property p_freq_in1;
    freq_sel1 && freq_armed && ch1.period_done |=> freq_ref_pulse;
  endproperty
  a_freq_in1: assert property (p_freq_in1) else $error("Input 1 pulse not routed.");

  property p_freq_unarmed;
    !freq_armed |=> !freq_ref_pulse;
  endproperty
  a_freq_unarmed: assert property (p_freq_unarmed) else $error("Pulse while unarmed.");

  property p_freq_error;
    freq_sel0 && ch0.short_phase |=> status_ff[`EVI_ST_FERR];
  endproperty
  a_freq_error: assert property (p_freq_error) else $error("Short phase not flagged.");

endmodule : external_event_input_control

// [test/event_source_model.sv]
`timescale 1ns/1ps
module event_source_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        lvl,
  input  wire logic [15:0] half,
  output logic             pin
);
  logic [15:0] cnt_ff;

  initial begin
    pin    = 1'b0;
    cnt_ff = 16'h0001;
  end

  // An idle source holds the asked level; a running one makes a square wave of 2*half cycles.
  always @(posedge clk) begin
    if (!run) begin
      pin    <= lvl;
      cnt_ff <= 16'h0001;
    end else if (cnt_ff >= half) begin
      pin    <= ~pin;
      cnt_ff <= 16'h0001;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule : event_source_model

// [test/external_event_input_control_tb.sv]
`timescale 1ns/1ps
module external_event_input_control_tb;
  typedef struct {string name; logic [31:0] msk; logic [31:0] exp;} note_t;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        event_input_0;
  logic        event_input_1;
  logic        auto_active = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        rd_seen = 1'b0;
  logic [31:0] rdata;
  logic        irq, receiver_active, force_off, time_sync_pulse, freq_ref_pulse, antenna_open;
  logic        run0 = 1'b0, run1 = 1'b0, lvl0 = 1'b0, lvl1 = 1'b0;
  logic [15:0] half0 = 16'h0064;
  logic [31:0] seed = 32'h51;
  logic [31:0] v;
  int          failures, n_checks, n_ts, n_fr, cyc, last_fr, fr_gap, base, i, ts_gap, last_ts;
  note_t       q[$];

  always #5 clk = ~clk;

  external_event_input_control u_dut (.clk(clk), .resetn(resetn),
    .event_input_0(event_input_0), .event_input_1(event_input_1), .auto_active(auto_active),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .receiver_active(receiver_active), .force_off(force_off),
    .time_sync_pulse(time_sync_pulse), .freq_ref_pulse(freq_ref_pulse),
    .antenna_open(antenna_open));
  event_source_model u_src0 (.clk(clk), .run(run0), .lvl(lvl0), .half(half0),
    .pin(event_input_0));
  event_source_model u_src1 (.clk(clk), .run(run1), .lvl(lvl1), .half(16'h0064),
    .pin(event_input_1));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    q.push_back('{n, m, e});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Read data stand only in the cycle after the strobe, so they are taken at the next edge.
  always @(posedge clk) begin : watch
    note_t nt;
    if (rd_seen && q.size() > 0) begin
      nt = q.pop_front();
      chk(nt.name, rdata & nt.msk, nt.exp);
    end
    rd_seen <= rd_en;
    if (time_sync_pulse === 1'b1) begin
      ts_gap  = cyc - last_ts;
      last_ts = cyc;
      n_ts++;
    end
    if (freq_ref_pulse === 1'b1) begin
      fr_gap  = cyc - last_fr;
      last_fr = cyc;
      n_fr++;
    end
    cyc++;
  end

  initial begin
    #500000;
    failures++;
    finish_test();
  end

  initial begin
    idle(16);
    chk("active_rst", receiver_active, 32'h1);
    chk("irq_rst", irq, 32'h0);
    resetn <= 1'b1;
    rd("ctrl_rst", 8'h00, 32'hffffffff, 32'h0);
    rd("status_rst", 8'h04, 32'hffffffff, 32'h0);
    rd("mask_rst", 8'h08, 32'hffffffff, 32'h0);
    v = xs();
    wr(8'h1c, v);
    rd("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    v = xs() & 32'h3f;
    wr(8'h00, v);
    rd("ctrl_rw", 8'h00, 32'h3f, v);
    $display("test registers done");
    wr(8'h00, 32'h11);
    idle(8);
    for (i = 1; i <= 4; i++) begin
      auto_active <= ~i[0];
      lvl0        <= i[0];
      idle(2);
      chk("active_sync", receiver_active, {31'h0, ~i[0]});
      idle(6);
      chk("active_pin", receiver_active, {31'h0, i[0]});
    end
    wr(8'h00, 32'h01);
    for (i = 1; i <= 4; i++) begin
      auto_active <= xs() & 32'h1;
      lvl0        <= i[0];
      idle(8);
      chk("force_off", force_off, {31'h0, ~i[0]});
      chk("active_off", receiver_active, {31'h0, i[0]});
    end
    wr(8'h00, 32'h10);
    auto_active <= 1'b0;
    idle(2);
    chk("active_auto", receiver_active, 32'h0);
    auto_active <= 1'b1;
    wr(8'h00, 32'h14);
    lvl1 <= 1'b1;
    idle(8);
    chk("active_in1", receiver_active, 32'h1);
    lvl1 <= 1'b0;
    idle(8);
    chk("inactive_in1", receiver_active, 32'h0);
    $display("test pin control done");
    wr(8'h00, 32'h08);
    wr(8'h04, 32'h1f);
    wr(8'h08, 32'h04);
    base = n_ts;
    lvl1 <= 1'b1;
    idle(10);
    chk("sync_count", n_ts - base, 32'h1);
    chk("irq_set", irq, 32'h1);
    rd("status_sync", 8'h04, 32'h04, 32'h04);
    wr(8'h04, 32'h04);
    idle(1);
    chk("irq_clr", irq, 32'h0);
    wr(8'h08, 32'h0);
    lvl1 <= 1'b0;
    idle(4);
    lvl1 <= 1'b1;
    idle(10);
    chk("irq_masked", irq, 32'h0);
    chk("sync_count2", n_ts - base, 32'h2);
    wr(8'h00, 32'h02);
    base = n_ts;
    lvl0 <= 1'b1;
    idle(10);
    chk("sync_in0", n_ts - base, 32'h1);
    rd("tstamp", 8'h14, 32'hffffffff, ts_gap - 1);
    $display("test time aid done");
    wr(8'h00, 32'h03);
    v = xs() | 32'h1;
    wr(8'h0c, v);
    rd("nom_freq", 8'h0c, 32'hffffffff, v);
    run0 <= 1'b1;
    idle(700);
    chk("ref_gap", fr_gap, 32'hc8);
    rd("period", 8'h10, 32'hffffffff, 32'hc8);
    wr(8'h04, 32'h1f);
    idle(300);
    rd("no_ferr", 8'h04, 32'h08, 32'h0);
    half0 <= 16'h0003;
    idle(40);
    rd("ferr", 8'h04, 32'h08, 32'h08);
    half0 <= 16'h0064;
    wr(8'h0c, 32'h0);
    idle(4);
    base = n_fr;
    idle(600);
    chk("unarmed", n_fr - base, 32'h0);
    run0 <= 1'b0;
    wr(8'h00, 32'h0c);
    wr(8'h0c, v);
    base = n_fr;
    run1 <= 1'b1;
    idle(700);
    chk("ref_count1", n_fr - base, 32'h3);
    chk("ref_gap1", fr_gap, 32'hc8);
    run1 <= 1'b0;
    idle(4);
    $display("test freq aid done");
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h1f);
    lvl1 <= 1'b0;
    idle(10);
    chk("ant_open", antenna_open, 32'h1);
    rd("ant_status", 8'h04, 32'h10, 32'h10);
    rd("ant_level", 8'h18, 32'h04, 32'h04);
    lvl1 <= 1'b1;
    idle(10);
    chk("ant_ok", antenna_open, 32'h0);
    rd("in1_ignored", 8'h04, 32'h02, 32'h0);
    $display("test antenna done");
    idle(4);
    finish_test();
  end
endmodule : external_event_input_control_tb
